// ==== logic/nir_pkg.sv ====
// Purpose: Shared constants and types for the namespace identify record block
// Assumes: One clock, 64-bit block counters, record read one byte at a time
// Notes: Byte offsets below are positions inside the identify record
package nir_pkg;
   localparam int unsigned NIR_CNT_W = 64;
   localparam logic [11:0] NIR_OFS_SIZE = 12'h000;
   localparam logic [11:0] NIR_OFS_CAP = 12'h008;
   localparam logic [11:0] NIR_OFS_USE = 12'h010;
   localparam logic [11:0] NIR_OFS_FEAT = 12'h018;
   localparam logic [11:0] NIR_OFS_NFMT = 12'h019;
   localparam logic [11:0] NIR_OFS_SEL = 12'h01a;
   localparam logic [11:0] NIR_OFS_MCAP = 12'h01b;
   localparam logic [11:0] NIR_OFS_DESC_LO = 12'h080;
   localparam logic [11:0] NIR_OFS_DESC_HI = 12'h0bf;
   localparam int unsigned NIR_FEAT_THIN_BIT = 0;
   localparam int unsigned NIR_SEL_EXT_BIT = 4;
   localparam int unsigned NIR_MCAP_SEP_BIT = 1;
   localparam int unsigned NIR_MCAP_EXT_BIT = 0;
   localparam int unsigned NIR_MAX_FMT = 16;
   localparam logic [63:0] NIR_CNT_RST = 64'h0;
   localparam logic [3:0] NIR_FMT_RST = 4'h0;

   // Static namespace configuration presented by the controller
   typedef struct packed {
      logic [63:0] block_count;
      logic [63:0] max_allocatable;
      logic thin_prov;
      logic [3:0] fmt_count_m1;
      logic [3:0] fmt_index;
      logic ext_meta;
      logic cap_sep;
      logic cap_ext;
   } nir_cfg_t;

   // Allocation events from the command path
   typedef struct packed {
      logic alloc;
      logic dealloc;
      logic dsm_supported;
   } nir_evt_t;
endpackage

// ==== logic/nir_alloc_cnt.sv ====
// Purpose: Counter of allocated blocks
// Assumes: At most one allocation and one deallocation event per cycle
// Notes: Saturates at capacity and at zero
`timescale 1ns/1ps
`default_nettype none
module nir_alloc_cnt
   import nir_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Events and limits
   input wire logic fmt_done_i,
   input var nir_evt_t evt_i,
   input wire logic thin_i,
   input wire logic [63:0] cap_i,
   // Count
   output logic [63:0] used_o
);
   logic [63:0] used_ff;
   logic [63:0] nxt_used;
   logic inc;
   logic dec;

   // Write or write-uncorrectable raises, dataset management lowers only while thin provisioning is on
   always_comb begin
      inc = evt_i.alloc && (used_ff < cap_i);
      dec = evt_i.dealloc && evt_i.dsm_supported && thin_i && (used_ff != NIR_CNT_RST);
      nxt_used = used_ff;
      if (!fmt_done_i) begin
         nxt_used = NIR_CNT_RST;
      end else if (inc && !dec) begin
         nxt_used = used_ff + 64'h1;
      end else if (dec && !inc) begin
         nxt_used = used_ff - 64'h1;
      end
      // Capacity may shrink below the count; clamp so the field exceeds it only in the cycle after it shrinks
      if (nxt_used > cap_i) begin
         nxt_used = cap_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         used_ff <= NIR_CNT_RST;
      end else begin
         used_ff <= nxt_used;
      end
   end

   assign used_o = used_ff;

   used_bound_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      used_ff <= cap_i || $changed(cap_i)) else $error("count above capacity");
   used_step_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (fmt_done_i && $past(fmt_done_i) && !$past(evt_i.alloc) && !$past(cap_i < used_ff))
      |-> used_ff <= $past(used_ff)) else $error("count rose without write");
endmodule
`default_nettype wire

// ==== logic/nir_byte_mux.sv ====
// Purpose: Byte selector for the fixed fields of the record
// Assumes: Fields already registered by the caller
// Notes: Purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
module nir_byte_mux
   import nir_pkg::*;
(
   // Field inputs
   input wire logic [63:0] size_i,
   input wire logic [63:0] cap_i,
   input wire logic [63:0] used_i,
   input wire logic [7:0] feat_i,
   input wire logic [7:0] nfmt_i,
   input wire logic [7:0] sel_i,
   input wire logic [7:0] mcap_i,
   input wire logic [7:0] desc_i,
   // Address and data
   input wire logic [11:0] addr_i,
   output logic [7:0] byte_o
);
   // Multi-byte counters are little-endian within the record
   always_comb begin
      byte_o = 8'h00;
      if (addr_i < NIR_OFS_CAP) begin
         byte_o = size_i[addr_i[2:0]*8 +: 8];
      end else if (addr_i < NIR_OFS_USE) begin
         byte_o = cap_i[addr_i[2:0]*8 +: 8];
      end else if (addr_i < NIR_OFS_FEAT) begin
         byte_o = used_i[addr_i[2:0]*8 +: 8];
      end else if (addr_i == NIR_OFS_FEAT) begin
         byte_o = feat_i;
      end else if (addr_i == NIR_OFS_NFMT) begin
         byte_o = nfmt_i;
      end else if (addr_i == NIR_OFS_SEL) begin
         byte_o = sel_i;
      end else if (addr_i == NIR_OFS_MCAP) begin
         byte_o = mcap_i;
      end else if (addr_i >= NIR_OFS_DESC_LO && addr_i <= NIR_OFS_DESC_HI) begin
         byte_o = desc_i;
      end
   end
endmodule
`default_nettype wire

// ==== logic/nir_top.sv ====
// Purpose: Namespace identify record builder, read one byte per request
// Assumes: Configuration comes from controller logic on the same clock
// Notes: Descriptor bytes come from an external table through desc_byte_i
`timescale 1ns/1ps
`default_nettype none
module nir_top
   import nir_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Namespace state
   input wire logic fmt_done_i,
   input wire logic avail_i,
   input var nir_cfg_t cfg_i,
   input var nir_evt_t evt_i,
   // Record read port
   input wire logic rd_req_i,
   input wire logic [11:0] rd_addr_i,
   input wire logic [7:0] desc_byte_i,
   output logic rd_ack_o,
   output logic [7:0] rd_data_o,
   // Visible fields
   output logic [63:0] size_o,
   output logic [63:0] cap_o,
   output logic [63:0] used_o,
   output logic ext_meta_o
);
   typedef enum logic [1:0] {
      NIR_IDLE = 2'b01,
      NIR_RESP = 2'b10
   } nir_state_t;

   nir_state_t state_ff;
   nir_state_t nxt_state;
   logic [63:0] size_ff;
   logic [63:0] cap_ff;
   logic [7:0] feat_ff;
   logic [7:0] nfmt_ff;
   logic [7:0] sel_ff;
   logic [7:0] mcap_ff;
   logic [7:0] data_ff;
   logic [63:0] nxt_size;
   logic [63:0] nxt_cap;
   logic [7:0] nxt_feat;
   logic [7:0] nxt_nfmt;
   logic [7:0] nxt_sel;
   logic [7:0] nxt_mcap;
   logic [7:0] nxt_data;
   logic [63:0] used;
   logic [7:0] mux_byte;
   logic [3:0] idx;
   logic desc_ok;

   // Field shaping: clamps protect the host from inconsistent configuration
   always_comb begin
      nxt_size = NIR_CNT_RST;
      nxt_cap = NIR_CNT_RST;
      if (fmt_done_i) begin
         nxt_size = cfg_i.block_count;
         if (!avail_i) begin
            nxt_cap = NIR_CNT_RST;
         end else if (!cfg_i.thin_prov) begin
            nxt_cap = cfg_i.block_count;
         end else if (cfg_i.max_allocatable > cfg_i.block_count) begin
            nxt_cap = cfg_i.block_count;
         end else begin
            nxt_cap = cfg_i.max_allocatable;
         end
         // An available formatted namespace never shows zero capacity
         if (avail_i && nxt_cap == NIR_CNT_RST) begin
            nxt_cap = 64'h1;
         end
         if (nxt_cap > nxt_size) begin
            nxt_size = nxt_cap;
         end
      end
      nxt_feat = 8'h00;
      nxt_feat[NIR_FEAT_THIN_BIT] = cfg_i.thin_prov;
      nxt_nfmt = {4'h0, cfg_i.fmt_count_m1};
      // Selected index outside the advertised set falls back to index 0
      idx = (cfg_i.fmt_index > cfg_i.fmt_count_m1) ? NIR_FMT_RST : cfg_i.fmt_index;
      nxt_sel = {4'h0, idx};
      nxt_sel[NIR_SEL_EXT_BIT] = cfg_i.ext_meta;
      // Sizes live in the external descriptor table; sizing advice stays there
      nxt_mcap = 8'h00;
      nxt_mcap[NIR_MCAP_SEP_BIT] = cfg_i.cap_sep;
      nxt_mcap[NIR_MCAP_EXT_BIT] = cfg_i.cap_ext;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         size_ff <= NIR_CNT_RST;
         cap_ff <= NIR_CNT_RST;
         feat_ff <= 8'h00;
         nfmt_ff <= 8'h00;
         sel_ff <= 8'h00;
         mcap_ff <= 8'h00;
      end else begin
         size_ff <= nxt_size;
         cap_ff <= nxt_cap;
         feat_ff <= nxt_feat;
         nfmt_ff <= nxt_nfmt;
         sel_ff <= nxt_sel;
         mcap_ff <= nxt_mcap;
      end
   end

   nir_alloc_cnt u_cnt (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .fmt_done_i(fmt_done_i),
      .evt_i(evt_i),
      .thin_i(feat_ff[NIR_FEAT_THIN_BIT]),
      .cap_i(cap_ff),
      .used_o(used)
   );

   // Descriptors past the advertised count read zero, keeping the table packed
   assign desc_ok = ((rd_addr_i - NIR_OFS_DESC_LO) >> 2) <= {8'h00, nfmt_ff[3:0]};

   nir_byte_mux u_mux (
      .size_i(size_ff),
      .cap_i(cap_ff),
      .used_i(used),
      .feat_i(feat_ff),
      .nfmt_i(nfmt_ff),
      .sel_i(sel_ff),
      .mcap_i(mcap_ff),
      .desc_i(desc_ok ? desc_byte_i : 8'h00),
      .addr_i(rd_addr_i),
      .byte_o(mux_byte)
   );

   // Read handshake: one request, answer on the next cycle
   always_comb begin
      nxt_state = state_ff;
      nxt_data = data_ff;
      case (state_ff)
         NIR_IDLE: begin
            if (rd_req_i) begin
               nxt_state = NIR_RESP;
               nxt_data = mux_byte;
            end
         end
         NIR_RESP: begin
            nxt_state = NIR_IDLE;
         end
         default: begin
            nxt_state = NIR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= NIR_IDLE;
         data_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         data_ff <= nxt_data;
      end
   end

   assign rd_ack_o = (state_ff == NIR_RESP);
   assign rd_data_o = data_ff;
   assign size_o = size_ff;
   assign cap_o = cap_ff;
   assign used_o = used;
   assign ext_meta_o = sel_ff[NIR_SEL_EXT_BIT];

   sequence rd_take_s;
      (state_ff == NIR_IDLE) && rd_req_i;
   endsequence
   sequence rd_ack_s;
      ##1 rd_ack_o ##1 !rd_ack_o;
   endsequence

   cap_le_size_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      cap_ff <= size_ff) else $error("capacity above size");
   cap_zero_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      fmt_done_i && $past(fmt_done_i) |-> ((cap_ff == 64'h0) == !$past(avail_i)))
      else $error("zero capacity mismatch");
   thin_off_eq_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      feat_ff[NIR_FEAT_THIN_BIT] == 1'b0 && $past(avail_i) |-> cap_ff == size_ff)
      else $error("capacity differs without thin");
   rsvd_zero_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      feat_ff[7:1] == 7'h00 && nfmt_ff[7:4] == 4'h0 && sel_ff[7:5] == 3'h0)
      else $error("reserved bits set");
   sel_in_range_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      sel_ff[3:0] <= nfmt_ff[3:0]) else $error("selected format out of range");
   mcap_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      mcap_ff[7:2] == 6'h00) else $error("capability reserved set");
   unfmt_zero_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !$past(fmt_done_i) |-> size_ff == 64'h0 && cap_ff == 64'h0)
      else $error("fields set before format");
   rd_ack_seq_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      rd_take_s |-> rd_ack_s) else $error("read answer timing");
   used_le_cap_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $stable(cap_ff) |-> used <= cap_ff) else $error("used above capacity");
   ext_bit_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      ext_meta_o == $past(cfg_i.ext_meta)) else $error("extended bit wrong");
endmodule
`default_nettype wire

// ==== test/nir_host_model.sv ====
// Purpose: Host reader model that issues one record read at a time
// Assumes: Same clock as the record builder
// Notes: The address shows its inverse once released, so a stale value never passes
`timescale 1ns/1ps
`default_nettype none
module nir_host_model (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Bench command
   input wire logic start_i,
   input wire logic [11:0] addr_i,
   // Read port
   input wire logic rd_ack_i,
   output logic rd_req_o,
   output logic [11:0] rd_addr_o
);
   // Request stays up through the ack edge, so the builder must ignore the repeat
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_req_o <= 1'b0;
         rd_addr_o <= 12'hfff;
      end else if (rd_req_o && rd_ack_i) begin
         rd_req_o <= 1'b0;
         rd_addr_o <= ~rd_addr_o;
      end else if (start_i && !rd_req_o) begin
         rd_req_o <= 1'b1;
         rd_addr_o <= addr_i;
      end
   end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the namespace identify record builder
// Assumes: Descriptor table is the low address byte xor a random salt
// Notes: Expected bytes come from a small reference of the record layout
`timescale 1ns/1ps
`default_nettype none
module tb;
   import nir_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic fmt = 1'b0;
   logic avail = 1'b0;
   logic start = 1'b0;
   logic [11:0] addr = 12'h0;
   nir_cfg_t cfg = '0;
   nir_evt_t evt = '0;
   logic req, ack, ext;
   logic [11:0] raddr;
   logic [7:0] rdata;
   logic [7:0] salt = 8'h0;
   logic [63:0] size, cap, used, sz, cp, used_m;
   logic [31:0] rnd = 32'hce24c504;
   logic [7:0] q[$];
   int err_count = 0;
   int n_tests = 0;

   nir_top i_nir_top (.clk_sys_i(clk), .nrst_i(nrst), .fmt_done_i(fmt), .avail_i(avail),
      .cfg_i(cfg), .evt_i(evt), .rd_req_i(req), .rd_addr_i(raddr),
      .desc_byte_i(raddr[7:0] ^ salt), .rd_ack_o(ack), .rd_data_o(rdata), .size_o(size),
      .cap_o(cap), .used_o(used), .ext_meta_o(ext));
   nir_host_model i_nir_host_model (.clk_sys_i(clk), .nrst_i(nrst), .start_i(start),
      .addr_i(addr), .rd_ack_i(ack), .rd_req_o(req), .rd_addr_o(raddr));

   // Free-running system clock
   initial begin
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Reference record byte, counters little-endian
   function automatic logic [7:0] exp_byte(input logic [11:0] a);
      logic [63:0] w;
      w = (a < 12'h008) ? sz : (a < 12'h010) ? cp : used_m;
      if (a < 12'h018) return w[8*a[2:0] +: 8];
      case (a)
         NIR_OFS_FEAT: return {7'h0, cfg.thin_prov};
         NIR_OFS_NFMT: return {4'h0, cfg.fmt_count_m1};
         NIR_OFS_SEL: return {3'h0, cfg.ext_meta,
            (cfg.fmt_index > cfg.fmt_count_m1) ? 4'h0 : cfg.fmt_index};
         NIR_OFS_MCAP: return {6'h0, cfg.cap_sep, cfg.cap_ext};
         default: ;
      endcase
      if (a >= NIR_OFS_DESC_LO && a <= NIR_OFS_DESC_HI &&
          (a - NIR_OFS_DESC_LO) / 4 <= cfg.fmt_count_m1) return a[7:0] ^ salt;
      return 8'h0;
   endfunction

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Index kept within the advertised count so the selection stays legal
   task automatic rcfg(output nir_cfg_t c);
      rnd = lfsr(rnd);
      c = '0;
      c.block_count = {rnd, ~rnd} | 64'h1;
      c.max_allocatable = {rnd[7:0], ~rnd, rnd[31:8]};
      c.fmt_count_m1 = rnd[3:0];
      c.fmt_index = rnd[7:4] & rnd[3:0];
      c.ext_meta = rnd[8];
      c.cap_sep = rnd[9];
      c.cap_ext = rnd[10];
   endtask

   task automatic apply(input nir_cfg_t c, input logic f, input logic av);
      cfg <= c;
      fmt <= f;
      avail <= av;
      salt <= rnd[7:0];
      sz = f ? c.block_count : 64'h0;
      cp = (!f || !av) ? 64'h0 :
         (!c.thin_prov || c.max_allocatable > sz) ? sz : c.max_allocatable;
      if (f && av && cp == 64'h0) cp = 64'h1;
      if (used_m > cp) used_m = cp;
      repeat (3) @(posedge clk);
      chk("size", sz, size);
      chk("cap", cp, cap);
      chk("used", used_m, used);
      chk("ext_meta", {63'h0, c.ext_meta}, {63'h0, ext});
   endtask

   // Gaps between pulses keep each event a separate block
   task automatic ev(input logic al, input logic de, input logic ds, input int n);
      repeat (n) begin
         evt <= '{alloc: al, dealloc: de, dsm_supported: ds};
         @(posedge clk);
         evt <= '0;
         @(posedge clk);
         if (al && !de && used_m < cp) used_m++;
         if (de && !al && ds && cfg.thin_prov && used_m != 64'h0) used_m--;
      end
      chk("used", used_m, used);
   endtask

   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      q.push_back(exp_byte(a));
      start <= 1'b1;
      addr <= a;
      @(posedge clk);
      start <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (req && n < 8);
   endtask

   // Each acknowledged read takes the oldest expected byte
   always @(posedge clk) begin
      if (ack === 1'b1) begin
         if (q.size() == 0) chk("extra_ack", 64'h0, 64'h1);
         else chk("rd_data", {56'h0, q.pop_front()}, {56'h0, rdata});
      end
   end

   task automatic test_done;
      chk("pending", 64'h0, 64'(q.size()));
      $display("counts: %0d compares, %0d mismatches", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      nir_cfg_t c;
      sz = 64'h0;
      cp = 64'h0;
      used_m = 64'h0;
      repeat (4) @(posedge clk);
      chk("rst_ack", 64'h0, {63'h0, ack});
      chk("rst_size", 64'h0, size);
      nrst <= 1'b1;
      $display("test reset done");
      rcfg(c);
      apply(c, 1'b0, 1'b1);
      ev(1'b1, 1'b0, 1'b1, 2);
      for (int a = 0; a < 16; a++) rd(a[11:0]);
      $display("test unformatted done");
      for (int i = 0; i < 4; i++) begin
         rcfg(c);
         c.thin_prov = i[0];
         apply(c, 1'b0, 1'b1);
         apply(c, 1'b1, 1'b1);
         for (int a = 0; a < 32; a++) rd(a[11:0]);
         for (int a = 124; a < 196; a++) rd(a[11:0]);
      end
      $display("test record done");
      c.block_count = 64'ha;
      c.max_allocatable = 64'h4;
      c.thin_prov = 1'b1;
      c.fmt_count_m1 = 4'h2;
      c.fmt_index = 4'h5;
      apply(c, 1'b1, 1'b1);
      ev(1'b1, 1'b0, 1'b0, 6);
      ev(1'b0, 1'b1, 1'b0, 2);
      ev(1'b0, 1'b1, 1'b1, 3);
      ev(1'b1, 1'b1, 1'b1, 1);
      for (int a = 16; a < 24; a++) rd(a[11:0]);
      rd(NIR_OFS_SEL);
      $display("test allocation done");
      apply(c, 1'b1, 1'b0);
      c.max_allocatable = 64'h0;
      apply(c, 1'b1, 1'b1);
      $display("test availability done");
      test_done;
   end

   // Full run is about 2000 cycles; ten times that marks a hang
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("MISMATCH watchdog expected finish seen timeout");
      test_done;
   end
endmodule
`default_nettype wire
